//--- core/rsc_pkg.sv
// Shared constants for the reset and strap configuration block
package rsc_pkg;

  // Strap pin positions within the strap vector
  localparam int STRAP_ADDR_LO = 0;
  localparam int STRAP_ADDR_HI = 1;
  localparam int STRAP_ROLE    = 2;
  localparam int STRAP_GPIO    = 3;
  localparam int STRAP_N       = 4;
  localparam int GPIO_N        = 4;
  localparam int ADDR_W        = 2;

  // Pin levels driven while the device is held in reset
  localparam logic RST_BIT_CLK   = 1'h0;
  localparam logic RST_FRAME_CLK = 1'h1;
  localparam logic RST_SDATA     = 1'h0;
  localparam logic RST_AUX_BIT   = 1'h0;
  localparam logic RST_AUX_FRAME = 1'h1;
  localparam logic RST_ERROR     = 1'h1;
  localparam logic RST_THRU2     = 1'h0;

  // Role strap level meaning slave, direction strap level meaning output
  localparam logic ROLE_SLAVE_LVL = 1'h1;
  localparam logic GPIO_OUT_LVL   = 1'h1;

  // Reset values of the captured configuration
  localparam logic [STRAP_N-1:0] CFG_RST = 4'h0;

  // Minimum hold-low time of the reset hold input
  localparam int CLK_MHZ         = 250;
  localparam int RST_HOLD_MIN_US = 200;
  localparam int RST_HOLD_CYC    = RST_HOLD_MIN_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PH_RESET = 2'h1,
    PH_RUN   = 2'h2
  } rsc_phase_t;

endpackage

//--- core/rsc_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module rsc_sync3 #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_V = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_ni,
  // Pin side
  input  wire logic [WIDTH-1:0] pin_i,
  // Filtered level
  output logic      [WIDTH-1:0] lvl_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  initial begin
    if (WIDTH < 1) $error("rsc_sync3: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      s1_r <= RST_V;
      s2_r <= RST_V;
      s3_r <= RST_V;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      lvl_o <= RST_V;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

//--- core/rsc_top.sv
// Reset hold handling, strap capture and reset pin states
`timescale 1ns/1ns
// Operation
// R1 - The device stays in reset while the reset hold input is low and runs once it is high.
// R2 - The outside party holds the reset hold input low for at least 200 us per reset.
// R3 - In reset the clock, data and error pins sit at fixed levels and host data floats; master clock outputs follow the oscillator, first through its input.
// R4 - In reset all four strap pins are inputs so their resistor levels can be read.
// R5 - The two address straps form a two-bit chip address, pulled up meaning one.
// R6 - The host sends the chip address in the two low bits, low bit first.
// R7 - A command write is taken only when its address equals the strapped address.
// R8 - Role strap pulled down means clock master, pulled up means clock slave.
// R9 - A master drives master, bit and frame clocks; a slave drives only the master clock. The code drives bit and frame clocks on both roles while in reset.
// R10 - A slave gets bit and frame clocks continuously from the master at matching polarity.
// R11 - The direction strap pulled down makes the four general pins inputs, up makes outputs.
// R12 - Strap levels are latched when the hold input rises and kept until the next reset.
module rsc_top
  import rsc_pkg::*;
#(
  parameter int CMD_W        = 8,
  parameter int HOLD_MIN_CYC = RST_HOLD_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // Reset hold and strap pins
  input  wire logic               reset_hold_i,
  input  wire logic [STRAP_N-1:0] strap_i,
  output logic      [STRAP_N-1:0] strap_o,
  output logic      [STRAP_N-1:0] strap_oe_o,
  // Clock pins
  input  wire logic               osc_clk_in_i,
  output logic                    receive_master_clock_o,
  output logic                    oscillator_clock_out_o,
  input  wire logic               rx_bit_clk_i,
  output logic                    rx_bit_clk_o,
  output logic                    rx_bit_clk_oe_o,
  input  wire logic               rx_frame_clk_i,
  output logic                    rx_frame_clk_o,
  output logic                    rx_frame_clk_oe_o,
  output logic                    auxiliary_bit_clock_o,
  output logic                    auxiliary_frame_clock_o,
  // Data and status pins
  output logic                    serial_data_o,
  output logic                    receive_error_flag_o,
  output logic                    first_through_out_o,
  output logic                    second_through_out_o,
  output logic                    host_sdo_o,
  output logic                    host_sdo_oe_o,
  // General purpose pins
  input  wire logic [GPIO_N-1:0]  gpio_i,
  output logic      [GPIO_N-1:0]  gpio_o,
  output logic      [GPIO_N-1:0]  gpio_oe_o,
  // Core side: functional values
  input  wire logic               f_master_clk_i,
  input  wire logic               f_osc_out_i,
  input  wire logic               f_bit_clk_i,
  input  wire logic               f_frame_clk_i,
  input  wire logic               f_aux_bit_i,
  input  wire logic               f_aux_frame_i,
  input  wire logic               f_sdata_i,
  input  wire logic               f_error_i,
  input  wire logic               f_thru1_i,
  input  wire logic               f_thru2_i,
  input  wire logic               f_host_sdo_i,
  input  wire logic               f_host_sdo_oe_i,
  input  wire logic [STRAP_N-1:0] f_strap_out_i,
  input  wire logic [GPIO_N-1:0]  f_gpio_out_i,
  // Core side: command writes from the host decoder
  input  wire logic               cmd_wr_i,
  input  wire logic [ADDR_W-1:0]  cmd_addr_i,
  input  wire logic [CMD_W-1:0]   cmd_data_i,
  output logic                    cmd_accept_o,
  output logic      [CMD_W-1:0]   cmd_data_o,
  // Core side: configuration and status
  output logic                    sys_run_o,
  output logic      [ADDR_W-1:0]  chip_addr_o,
  output logic                    clk_slave_o,
  output logic                    gpio_dir_out_o,
  output logic                    slave_bit_clk_o,
  output logic                    slave_frame_clk_o,
  output logic      [GPIO_N-1:0]  gpio_in_o,
  output logic                    hold_short_o
);

  logic               rst_s1_r;
  logic               rst_n;
  logic               hold_lvl;
  logic [STRAP_N-1:0] strap_lvl;
  logic [GPIO_N-1:0]  gpio_lvl;
  logic [1:0]         sclk_lvl;
  logic               osc_lvl;
  rsc_phase_t         ph_r;
  logic [STRAP_N-1:0] cfg_r;
  logic [31:0]        hold_cnt_r;
  logic               in_rst;

  initial begin
    if (CMD_W < 1) $error("rsc_top: CMD_W must be at least 1");
    if (HOLD_MIN_CYC < 1) $error("rsc_top: HOLD_MIN_CYC must be at least 1");
  end

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_s1_r <= 1'h1;
      rst_n    <= rst_s1_r;
    end
  end

  rsc_sync3 #(.WIDTH(1), .RST_V(1'h0)) u_hold (
    .clk_i(clk_i), .rst_ni(rst_n), .pin_i(reset_hold_i), .lvl_o(hold_lvl));
  rsc_sync3 #(.WIDTH(STRAP_N), .RST_V(CFG_RST)) u_strap (
    .clk_i(clk_i), .rst_ni(rst_n), .pin_i(strap_i), .lvl_o(strap_lvl));
  rsc_sync3 #(.WIDTH(GPIO_N), .RST_V(4'h0)) u_gpio (
    .clk_i(clk_i), .rst_ni(rst_n), .pin_i(gpio_i), .lvl_o(gpio_lvl));
  rsc_sync3 #(.WIDTH(2), .RST_V(2'h0)) u_sclk (
    .clk_i(clk_i), .rst_ni(rst_n), .pin_i({rx_frame_clk_i, rx_bit_clk_i}), .lvl_o(sclk_lvl));
  // Oscillator follows at sampling resolution only; a true clock path bypasses this block
  rsc_sync3 #(.WIDTH(1), .RST_V(1'h0)) u_osc (
    .clk_i(clk_i), .rst_ni(rst_n), .pin_i(osc_clk_in_i), .lvl_o(osc_lvl));

  // Phase tracks the filtered hold level
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= PH_RESET;
    end else begin
      ph_r <= hold_lvl ? PH_RUN : PH_RESET; // [R1]
    end
  end

  assign in_rst = (ph_r == PH_RESET);

  // Straps sampled every reset cycle, frozen from the release onward
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RST;
    end else if (in_rst) begin
      cfg_r <= strap_lvl; // [R12]
    end
  end

  // Flags a hold-low pulse shorter than the required minimum
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r   <= 32'h0;
      hold_short_o <= 1'h0;
    end else if (in_rst) begin
      if (hold_cnt_r < 32'(HOLD_MIN_CYC)) begin
        hold_cnt_r <= hold_cnt_r + 32'h1;
      end
    end else begin
      if (hold_cnt_r != 32'h0) begin
        hold_short_o <= (hold_cnt_r < 32'(HOLD_MIN_CYC)); // [R2]
      end
      hold_cnt_r <= 32'h0;
    end
  end

  // Configuration outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_run_o      <= 1'h0;
      chip_addr_o    <= 2'h0;
      clk_slave_o    <= 1'h0;
      gpio_dir_out_o <= 1'h0;
    end else begin
      sys_run_o      <= !in_rst; // [R1]
      chip_addr_o    <= {cfg_r[STRAP_ADDR_HI], cfg_r[STRAP_ADDR_LO]}; // [R5]
      clk_slave_o    <= (cfg_r[STRAP_ROLE] == ROLE_SLAVE_LVL); // [R8]
      gpio_dir_out_o <= (cfg_r[STRAP_GPIO] == GPIO_OUT_LVL); // [R11]
    end
  end

  // Pin states: fixed in reset except the master clocks and first through output, functional afterwards
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      receive_master_clock_o  <= 1'h0;
      oscillator_clock_out_o  <= 1'h0;
      rx_bit_clk_o            <= RST_BIT_CLK;
      rx_frame_clk_o          <= RST_FRAME_CLK;
      auxiliary_bit_clock_o   <= RST_AUX_BIT;
      auxiliary_frame_clock_o <= RST_AUX_FRAME;
      serial_data_o           <= RST_SDATA;
      receive_error_flag_o    <= RST_ERROR;
      second_through_out_o    <= RST_THRU2;
      host_sdo_o              <= 1'h0;
      host_sdo_oe_o           <= 1'h0;
      first_through_out_o     <= 1'h0;
    end else begin
      receive_master_clock_o  <= in_rst ? osc_lvl : f_master_clk_i; // [R3]
      oscillator_clock_out_o  <= in_rst ? osc_lvl : f_osc_out_i; // [R3]
      rx_bit_clk_o            <= in_rst ? RST_BIT_CLK : f_bit_clk_i;
      rx_frame_clk_o          <= in_rst ? RST_FRAME_CLK : f_frame_clk_i;
      auxiliary_bit_clock_o   <= in_rst ? RST_AUX_BIT : f_aux_bit_i;
      auxiliary_frame_clock_o <= in_rst ? RST_AUX_FRAME : f_aux_frame_i;
      serial_data_o           <= in_rst ? RST_SDATA : f_sdata_i;
      receive_error_flag_o    <= in_rst ? RST_ERROR : f_error_i;
      second_through_out_o    <= in_rst ? RST_THRU2 : f_thru2_i;
      host_sdo_o              <= in_rst ? 1'h0 : f_host_sdo_i;
      host_sdo_oe_o           <= in_rst ? 1'h0 : f_host_sdo_oe_i; // [R3]
      // First through output passes the selected input even in reset
      first_through_out_o     <= f_thru1_i;
    end
  end

  // Pin directions
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_oe_o        <= 4'h0;
      strap_o           <= 4'h0;
      rx_bit_clk_oe_o   <= 1'h1;
      rx_frame_clk_oe_o <= 1'h1;
      gpio_oe_o         <= 4'h0;
      gpio_o            <= 4'h0;
    end else begin
      strap_oe_o        <= in_rst ? 4'h0 : 4'hF; // [R4]
      strap_o           <= f_strap_out_i;
      // Reset levels are driven on both roles; role applies only once running
      rx_bit_clk_oe_o   <= in_rst || (cfg_r[STRAP_ROLE] != ROLE_SLAVE_LVL); // [R9]
      rx_frame_clk_oe_o <= in_rst || (cfg_r[STRAP_ROLE] != ROLE_SLAVE_LVL); // [R9]
      gpio_oe_o         <= {GPIO_N{!in_rst && (cfg_r[STRAP_GPIO] == GPIO_OUT_LVL)}}; // [R11]
      gpio_o            <= f_gpio_out_i;
    end
  end

  // Inputs seen by the core; slave clocks rely on the master running them [R10]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slave_bit_clk_o   <= 1'h0;
      slave_frame_clk_o <= 1'h0;
      gpio_in_o         <= 4'h0;
    end else begin
      slave_bit_clk_o   <= sclk_lvl[0];
      slave_frame_clk_o <= sclk_lvl[1];
      gpio_in_o         <= gpio_lvl;
    end
  end

  // Host address arrives low bit first as bits [1:0] [R6]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_accept_o <= 1'h0;
      cmd_data_o   <= '0;
    end else begin
      cmd_accept_o <= cmd_wr_i && sys_run_o && (cmd_addr_i == chip_addr_o); // [R7]
      if (cmd_wr_i && sys_run_o && (cmd_addr_i == chip_addr_o)) begin
        cmd_data_o <= cmd_data_i;
      end
    end
  end

  chk_hold_low_reset: assert property (@(posedge clk_i) disable iff (!rst_n) // [R1]
    !hold_lvl |=> ##1 !sys_run_o)
    else $error("device left reset while hold input low");

  chk_reset_pin_levels: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    in_rst |=> (!rx_bit_clk_o && rx_frame_clk_o && !auxiliary_bit_clock_o
               && auxiliary_frame_clock_o && receive_error_flag_o && !serial_data_o
               && !second_through_out_o && !host_sdo_oe_o))
    else $error("reset pin levels wrong");

  chk_straps_input: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
    in_rst |=> (strap_oe_o == 4'h0))
    else $error("strap pin driven during reset");

  chk_cfg_frozen: assert property (@(posedge clk_i) disable iff (!rst_n) // [R12]
    sys_run_o && $past(sys_run_o) |-> $stable(chip_addr_o) && $stable(clk_slave_o)
      && $stable(gpio_dir_out_o))
    else $error("configuration changed while running");

  chk_cmd_match: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
    cmd_wr_i && sys_run_o && (cmd_addr_i == chip_addr_o) |=> cmd_accept_o
      && (cmd_data_o == $past(cmd_data_i)))
    else $error("matching command not accepted");

  chk_cmd_reject: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
    cmd_wr_i && (cmd_addr_i != chip_addr_o) |=> !cmd_accept_o)
    else $error("command for another address accepted");

  chk_master_drive: assert property (@(posedge clk_i) disable iff (!rst_n) // [R9]
    sys_run_o && !clk_slave_o |-> rx_bit_clk_oe_o && rx_frame_clk_oe_o)
    else $error("master not driving bit and frame clocks");

  chk_slave_release: assert property (@(posedge clk_i) disable iff (!rst_n) // [R9]
    sys_run_o && clk_slave_o |-> !rx_bit_clk_oe_o && !rx_frame_clk_oe_o)
    else $error("slave driving bit or frame clock");

  chk_gpio_dir: assert property (@(posedge clk_i) disable iff (!rst_n) // [R11]
    sys_run_o |-> (gpio_oe_o == {GPIO_N{gpio_dir_out_o}}))
    else $error("general pin direction disagrees with strap");

endmodule

//--- verif/rsc_host_model.sv
// Host model: drives the reset hold pin and issues command writes
`timescale 1ns/1ns
module rsc_host_model
  import rsc_pkg::*;
#(
  parameter int CMD_W = 8
) (
  // Clock
  input  wire logic              clk_i,
  // Pins towards the device
  output logic                   reset_hold_o,
  output logic                   cmd_wr_o,
  output logic      [ADDR_W-1:0] cmd_addr_o,
  output logic      [CMD_W-1:0]  cmd_data_o
);
  initial begin
    reset_hold_o = 1'h0;
    cmd_wr_o     = 1'h0;
    cmd_addr_o   = 2'h0;
    cmd_data_o   = '0;
  end

  // Low for the asked span, then released high
  task automatic hold_reset(input int cyc);
    @(negedge clk_i);
    reset_hold_o = 1'h0;
    repeat (cyc) @(negedge clk_i);
    reset_hold_o = 1'h1;
  endtask

  // One write; address bit 0 is the low chip address bit
  task automatic write(input logic [ADDR_W-1:0] addr, input logic [CMD_W-1:0] data);
    @(negedge clk_i);
    cmd_wr_o   = 1'h1;
    cmd_addr_o = addr;
    cmd_data_o = data;
    @(negedge clk_i);
    cmd_wr_o   = 1'h0;
    // Released bus shows the inverse, never a stale copy
    cmd_addr_o = ~addr;
    cmd_data_o = ~data;
  endtask
endmodule

//--- verif/testbench.sv
// Self-checking testbench for the reset and strap configuration block
`timescale 1ns/1ns
module testbench;
  import rsc_pkg::*;
  localparam int HOLD = 20;
  logic        clk, nrst, hold, osc, rbk, rfk, cwr;
  logic [3:0]  strap, gpin, soe, goe, gin;
  logic [11:0] fs;
  logic [1:0]  caddr, addr_h;
  logic [7:0]  cdat_h, cdata;
  logic        receive_master_clock, oscillator_clock_out, rbo, rboe, rfo, rfoe, abk, afk, sdo, err, thru2, hoe;
  logic        acc, run, slv, gdir, sbk, sfk, hshort;
  logic        thru1, hsdo;
  logic [3:0]  sout, gout;
  int          bad_count, num_checks;

  rsc_host_model #(.CMD_W(8)) host_u (.clk_i(clk), .reset_hold_o(hold), .cmd_wr_o(cwr),
    .cmd_addr_o(addr_h), .cmd_data_o(cdat_h));

  rsc_top #(.CMD_W(8), .HOLD_MIN_CYC(HOLD)) dut_u (
    .clk_i(clk), .nrst_i(nrst), .reset_hold_i(hold), .strap_i(strap), .strap_o(sout),
    .strap_oe_o(soe), .osc_clk_in_i(osc), .receive_master_clock_o(receive_master_clock),
    .oscillator_clock_out_o(oscillator_clock_out), .rx_bit_clk_i(rbk), .rx_bit_clk_o(rbo),
    .rx_bit_clk_oe_o(rboe), .rx_frame_clk_i(rfk), .rx_frame_clk_o(rfo),
    .rx_frame_clk_oe_o(rfoe), .auxiliary_bit_clock_o(abk), .auxiliary_frame_clock_o(afk),
    .serial_data_o(sdo), .receive_error_flag_o(err), .first_through_out_o(thru1),
    .second_through_out_o(thru2), .host_sdo_o(hsdo), .host_sdo_oe_o(hoe), .gpio_i(gpin),
    .gpio_o(gout), .gpio_oe_o(goe), .f_master_clk_i(fs[0]), .f_osc_out_i(fs[1]),
    .f_bit_clk_i(fs[2]), .f_frame_clk_i(fs[3]), .f_aux_bit_i(fs[4]), .f_aux_frame_i(fs[5]),
    .f_sdata_i(fs[6]), .f_error_i(fs[7]), .f_thru1_i(fs[8]), .f_thru2_i(fs[9]),
    .f_host_sdo_i(fs[10]), .f_host_sdo_oe_i(fs[11]), .f_strap_out_i(4'h5),
    .f_gpio_out_i(4'hA), .cmd_wr_i(cwr), .cmd_addr_i(addr_h), .cmd_data_i(cdat_h),
    .cmd_accept_o(acc), .cmd_data_o(cdata), .sys_run_o(run), .chip_addr_o(caddr),
    .clk_slave_o(slv), .gpio_dir_out_o(gdir), .slave_bit_clk_o(sbk),
    .slave_frame_clk_o(sfk), .gpio_in_o(gin), .hold_short_o(hshort));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the run level
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (run !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(run, v);
  endtask

  task automatic t_reset_pins();
    @(negedge clk);
    osc = 1'h1;
    repeat (8) @(negedge clk);
    chk({rbo, rboe, rfo, rfoe, abk, afk, sdo, err, thru2, hoe, soe, run, receive_master_clock, oscillator_clock_out, thru1, goe},
        {RST_BIT_CLK, 1'h1, RST_FRAME_CLK, 1'h1, RST_AUX_BIT, RST_AUX_FRAME, RST_SDATA,
         RST_ERROR, RST_THRU2, 1'h0, 4'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'h0});
    osc = 1'h0;
    repeat (8) @(negedge clk);
    chk({receive_master_clock, oscillator_clock_out}, 2'h0);
    // A write while held in reset must be ignored
    host_u.write(2'h0, 8'h3C);
    repeat (3) @(negedge clk);
    chk({acc, cdata}, 9'h000);
    $display("test reset_pins done");
  endtask

  // Every strap combination, then straps disturbed while running
  task automatic t_straps();
    logic [3:0] c;
    // Oscillator high so run-time master clocks differ from their reset copies
    osc = 1'h1;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      strap = c;
      rbk = c[0];
      rfk = c[1];
      gpin = c;
      host_u.hold_reset(HOLD + 5);
      wait_run(1'h1);
      @(negedge clk);
      chk({caddr, slv, gdir}, {c[1], c[0], c[2], c[3]});
      chk({rboe, rfoe, goe}, {~c[2], ~c[2], {4{c[3]}}});
      chk({sbk, sfk, gin}, {c[0], c[1], c});
      chk({rbo, rfo, abk, afk, sdo, err, thru2, hoe, receive_master_clock, oscillator_clock_out}, 10'h2AC);
      chk({sout, gout, hsdo, thru1}, {4'h5, 4'hA, 1'h1, 1'h1});
      // Slave: the master keeps its bit and frame clocks running
      if (c[2]) begin
        rbk = ~c[0];
        rfk = ~c[1];
        repeat (6) @(negedge clk);
        chk({sbk, sfk}, {~c[0], ~c[1]});
      end
      strap = ~c;
      repeat (8) @(negedge clk);
      chk({caddr, slv, gdir, run}, {c[1], c[0], c[2], c[3], 1'h1});
    end
    $display("test straps done");
  endtask

  // Only the strapped address is taken
  task automatic t_cmd();
    logic [1:0] hits;
    logic [7:0] last;
    strap = 4'h2;
    host_u.hold_reset(HOLD + 5);
    wait_run(1'h1);
    // Nothing accepted since power-up, so held data is still its reset value
    last = 8'h00;
    for (int a = 0; a < 4; a++) begin
      host_u.write(a[1:0], 8'h50 + 8'(a));
      hits = {1'h0, acc};
      @(negedge clk);
      hits = hits + {1'h0, acc};
      if (a == 2) last = 8'h52;
      chk({hits, cdata}, {(a == 2) ? 2'h1 : 2'h0, last});
    end
    $display("test cmd done");
  endtask

  // Too short a hold is flagged, a long one clears the flag
  task automatic t_short();
    host_u.hold_reset(5);
    wait_run(1'h0);
    wait_run(1'h1);
    repeat (3) @(negedge clk);
    chk(hshort, 1'h1);
    host_u.hold_reset(HOLD + 5);
    wait_run(1'h1);
    repeat (3) @(negedge clk);
    chk(hshort, 1'h0);
    $display("test short_hold done");
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    num_checks = 0;
    nrst = 1'h0;
    osc = 1'h0;
    rbk = 1'h0;
    rfk = 1'h0;
    strap = 4'h0;
    gpin = 4'h0;
    fs = 12'hF54;
    repeat (4) @(negedge clk);
    nrst = 1'h1;
    t_reset_pins();
    t_straps();
    t_cmd();
    t_short();
    test_done();
  end

  // Whole run needs about 830 cycles
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
